// File: hdl/status_reg_pkg.sv
// Purpose: Constants for the serial flash status register block
// Assumes: Standard single-bit serial mode, mode 0 sampling
// Notes: Opcodes, bit positions and timing counts live here
package status_reg_pkg;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
   localparam logic [7:0] OP_QUAD_IF_ENABLE = 8'h38;
   localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
   localparam logic [7:0] OP_OTP_ENTER = 8'h3A;
   // Normal view bit positions
   localparam int BIT_BUSY = 0;
   localparam int BIT_WEL = 1;
   localparam int BIT_BP_LO = 2;
   localparam int BIT_PIN_DIS = 6;
   localparam int BIT_REG_PROT = 7;
   // One-time view bit positions
   localparam int BIT_SECURE_SECTOR2_LOCK = 1;
   localparam int BIT_SECURE_SECTOR1_LOCK = 2;
   localparam int BIT_BOOT_EN = 3;
   localparam int BIT_BOOT_SIZE = 4;
   localparam int BIT_TOP_BOT = 6;
   localparam int BIT_SECURE_SECTOR0_LOCK = 7;
   localparam logic [5:0] NV_RESET = 6'h00;
   localparam logic [7:0] OTP_RESET = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Self-timed cycle lengths
   localparam int CLK_MHZ = 100;
   localparam int WRITE_CYCLE_US = 10;
   localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_US * CLK_MHZ;
   localparam int ARRAY_CYCLE_US = 40;
   localparam int ARRAY_CYCLE_CYC = ARRAY_CYCLE_US * CLK_MHZ;
   typedef enum logic [1:0] {SH_OPCODE, SH_DATA, SH_ADDR, SH_IDLE} shift_phase_t;
endpackage

// File: hdl/status_reg_core.sv
// Purpose: Status register and its commands for a serial flash
// Assumes: Host keeps cs low for whole commands; sclk idles between frames
// Notes: Link side on sclk_i, register side on clock_i; events cross by toggle
// What this block does
// - Status read 05h answered even while busy
// - Status byte repeats while chip select low
// - Normal view: protect, pin-disable, four BP, latch, busy
// - One-time view: locks, top-bottom, size, boot enable
// - Busy high during any self-timed cycle
// - Latch clear refuses writes, programs, erases
// - Any nonzero BP rejects page program, sector and block erase
// - Chip erase only with all BP zero
// - Pin-disable set ignores protect and hold pins
// - EBh and 38h accepted regardless of pin-disable
// - Protect bit plus low pin locks register
// - Security locks program once, then stay set
// - Boot enable freezes top-bottom and size
// - Size select: 1 sector, 0 block
// - Top-bottom: 1 bottom, 0 top
// - Status write opcode 01h needs latch set
// - Status write sets busy, clears latch at cycle end
// - Chip select must rise after sixteenth bit
// - Self-timed cycle sets busy, clears latch after
// - Write-enable decode sets the latch
// - Opcode 06h sets latch
// - Opcode 04h clears latch and leaves one-time mode
`timescale 1ns/1ps
`default_nettype none
module status_reg_core
   import status_reg_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYCLE_CYC,
   parameter int ARRAY_CYCLES = ARRAY_CYCLE_CYC,
   parameter logic [15:0] BP_REGION_TABLE [16] = '{default: 16'h0000}
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic serial_in_pin_i,
   input wire logic write_protect_n_i,
   input wire logic hold_n_i,
   output logic serial_out_o,
   output logic serial_out_oe_o,
   output logic busy_flag_o,
   output logic write_enable_latch_o,
   output logic hardware_protected_mode_o,
   output logic quad_interface_enable_cmd_o,
   output logic [15:0] protected_region_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Link side, sclk domain; reset by cs high
   logic [7:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic [4:0] addr_cnt_q;
   shift_phase_t phase_q;
   logic [7:0] opcode_q;
   logic [7:0] wdata_q;
   logic data_full_q;
   logic [7:0] tx_q;
   logic [7:0] status_view;
   logic [7:0] status_link_s1_q;
   logic [7:0] status_link_q;
   logic hold_active;

   // Status view built in clock domain, resampled on sclk
   // Quasi-static while reading; tear-free enough for polling
   always_ff @(posedge sclk_i) begin
      status_link_s1_q <= status_view;
      status_link_q <= status_link_s1_q;
   end

   assign hold_active = 1'b0;

   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         shift_q <= 8'h00;
         bit_cnt_q <= 3'h0;
         addr_cnt_q <= 5'h00;
         phase_q <= SH_OPCODE;
         opcode_q <= 8'h00;
         wdata_q <= 8'h00;
         data_full_q <= 1'b0;
      end else begin
         shift_q <= {shift_q[6:0], serial_in_pin_i};
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (bit_cnt_q == BIT_LAST) begin
            case (phase_q)
               SH_OPCODE: begin
                  opcode_q <= {shift_q[6:0], serial_in_pin_i};
                  phase_q <= SH_DATA;
               end
               SH_DATA: begin
                  if (!data_full_q) begin
                     wdata_q <= {shift_q[6:0], serial_in_pin_i};
                     data_full_q <= 1'b1;
                  end else begin
                     data_full_q <= 1'b0;
                     phase_q <= SH_IDLE;
                  end
               end
               SH_ADDR: phase_q <= SH_IDLE;
               SH_IDLE: phase_q <= SH_IDLE;
               default: phase_q <= SH_IDLE;
            endcase
         end
         if (phase_q == SH_DATA && addr_cnt_q != 5'h1F && bit_cnt_q == 3'h0) begin
            addr_cnt_q <= addr_cnt_q + 5'h01;
         end
      end
   end

   // Output shifts on falling edge, repeating status byte
   always_ff @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         tx_q <= 8'h00;
         serial_out_o <= 1'b0;
         serial_out_oe_o <= 1'b0;
      end else if (phase_q != SH_OPCODE && opcode_q == OP_STATUS_READ) begin
         serial_out_oe_o <= 1'b1;
         if (bit_cnt_q == 3'h0) begin
            serial_out_o <= status_link_q[7];
            tx_q <= {status_link_q[6:0], 1'b0};
         end else begin
            serial_out_o <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame end crossing: toggle carries opcode, data and exact-length flag
   // Known start value; the cs domain has no reset of its own
   logic frame_tgl_q = 1'b0;
   logic [7:0] frame_op_q;
   logic [7:0] frame_data_q;
   logic frame_exact_q;
   logic [2:0] frame_sync_q;
   logic frame_evt;

   always_ff @(posedge cs_n_i) begin
      frame_tgl_q <= ~frame_tgl_q;
      frame_op_q <= opcode_q;
      frame_data_q <= wdata_q;
      // Exactly 16 bits: data byte full and counter wrapped
      frame_exact_q <= data_full_q && bit_cnt_q == 3'h0 && phase_q == SH_DATA;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         frame_sync_q <= 3'h0;
      end else begin
         frame_sync_q <= {frame_sync_q[1:0], frame_tgl_q};
      end
   end
   assign frame_evt = frame_sync_q[2] ^ frame_sync_q[1];

   // Protect pin synchronised before use
   logic [1:0] wp_sync_q;
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wp_sync_q <= 2'b11;
      end else begin
         wp_sync_q <= {wp_sync_q[0], write_protect_n_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register side
   logic [5:0] nv_q;
   logic [7:0] otp_q;
   logic otp_mode_q;
   logic wel_q;
   logic busy_q;
   logic [31:0] busy_cnt_q;
   logic [7:0] pend_data_q;
   logic pend_status_q;
   logic hardware_protected_mode;
   logic bp_any;
   logic [7:0] op;
   logic [7:0] otp_next;

   assign op = frame_op_q;
   assign bp_any = |nv_q[3:0];
   // Pins ignored when pin-disable set
   assign hardware_protected_mode = nv_q[BIT_REG_PROT - BIT_BP_LO] && !wp_sync_q[1]
                && !nv_q[BIT_PIN_DIS - BIT_BP_LO];

   always_comb begin
      status_view = {nv_q, wel_q, busy_q};
      if (otp_mode_q) begin
         status_view = {otp_q[7:1], busy_q};
      end
   end

   // One-time bits only go to 1; boot enable freezes size and top-bottom
   always_comb begin
      otp_next = otp_q | pend_data_q;
      otp_next[5] = 1'b0;
      otp_next[0] = 1'b0;
      if (otp_q[BIT_BOOT_EN]) begin
         otp_next[BIT_TOP_BOT] = otp_q[BIT_TOP_BOT];
         otp_next[BIT_BOOT_SIZE] = otp_q[BIT_BOOT_SIZE];
      end
   end

   // Self-timed cycle
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         busy_cnt_q <= 32'h0;
         pend_status_q <= 1'b0;
         pend_data_q <= 8'h00;
      end else if (busy_q) begin
         if (busy_cnt_q == 32'h1) begin
            busy_q <= 1'b0;
            pend_status_q <= 1'b0;
         end
         busy_cnt_q <= busy_cnt_q - 32'h1;
      end else if (frame_evt && wel_q) begin
         if (op == OP_STATUS_WRITE && frame_exact_q && !hardware_protected_mode) begin
            busy_q <= 1'b1;
            busy_cnt_q <= 32'(WRITE_CYCLES);
            pend_status_q <= 1'b1;
            pend_data_q <= frame_data_q;
         end else if ((op == OP_PAGE_PROGRAM || op == OP_SECTOR_ERASE
                       || op == OP_BLOCK_ERASE) && !bp_any) begin
            busy_q <= 1'b1;
            busy_cnt_q <= 32'(ARRAY_CYCLES);
         end else if (op == OP_CHIP_ERASE && !bp_any) begin
            busy_q <= 1'b1;
            busy_cnt_q <= 32'(ARRAY_CYCLES);
         end
      end
   end

   // Register contents committed at cycle end
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         nv_q <= NV_RESET;
         otp_q <= OTP_RESET;
      end else if (busy_q && busy_cnt_q == 32'h1 && pend_status_q) begin
         if (otp_mode_q) begin
            otp_q <= otp_next;
         end else begin
            nv_q <= pend_data_q[7:2];
         end
      end
   end

   // Latch and mode
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wel_q <= 1'b0;
         otp_mode_q <= 1'b0;
      end else if (busy_q) begin
         if (busy_cnt_q == 32'h1) begin
            wel_q <= 1'b0;
         end
      end else if (frame_evt) begin
         case (op)
            OP_WRITE_ENABLE: wel_q <= 1'b1;
            OP_WRITE_DISABLE: begin
               wel_q <= 1'b0;
               otp_mode_q <= 1'b0;
            end
            OP_OTP_ENTER: otp_mode_q <= 1'b1;
            default: wel_q <= wel_q;
         endcase
      end
   end

   // Quad commands accepted whatever pin-disable holds
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         quad_interface_enable_cmd_o <= 1'b0;
      end else if (frame_evt && !busy_q &&
                   (op == OP_QUAD_IF_ENABLE || op == OP_QUAD_IO_READ)) begin
         quad_interface_enable_cmd_o <= 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         busy_flag_o <= 1'b0;
         write_enable_latch_o <= 1'b0;
         hardware_protected_mode_o <= 1'b0;
         protected_region_o <= 16'h0000;
      end else begin
         busy_flag_o <= busy_q;
         write_enable_latch_o <= wel_q;
         hardware_protected_mode_o <= hardware_protected_mode;
         protected_region_o <= BP_REGION_TABLE[nv_q[3:0]];
      end
   end
endmodule
`default_nettype wire

// File: test/status_reg_checker.sv
// Purpose: Port assertions for the status register block
// Assumes: WRITE_CYCLES of at least 8
// Notes: Clock domain outputs only; link side judged by the bench
`timescale 1ns/1ps
`default_nettype none
module status_reg_checker (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic write_protect_n_i,
   input wire logic busy_flag_o,
   input wire logic write_enable_latch_o,
   input wire logic hardware_protected_mode_o,
   input wire logic quad_interface_enable_cmd_o,
   input wire logic [15:0] protected_region_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_start; $rose(busy_flag_o); endsequence
   sequence s_end; $fell(busy_flag_o); endsequence
   a_latch_set_idle: assert property ($rose(write_enable_latch_o) |-> !busy_flag_o)
      else $error("latch set during cycle");
   a_busy_needs_latch: assert property (s_start |-> $past(write_enable_latch_o))
      else $error("cycle without latch");
   a_busy_min_len: assert property (s_start |-> busy_flag_o [*8])
      else $error("busy too short");
   a_busy_keeps_latch: assert property (busy_flag_o |-> write_enable_latch_o)
      else $error("latch lost in cycle");
   a_end_clears_latch: assert property (s_end |-> ##[0:2] !write_enable_latch_o)
      else $error("latch kept after cycle");
   a_quad_sticky: assert property (quad_interface_enable_cmd_o |=> quad_interface_enable_cmd_o)
      else $error("quad flag dropped");
   a_pin_high_free: assert property (write_protect_n_i [*5] |-> !hardware_protected_mode_o)
      else $error("locked with pin high");
   a_region_late: assert property ($changed(protected_region_o) |-> !write_enable_latch_o)
      else $error("region moved early");
endmodule
bind status_reg_core status_reg_checker chk_u (
   .clock_i(clock_i),
   .rst_i(rst_i),
   .write_protect_n_i(write_protect_n_i),
   .busy_flag_o(busy_flag_o),
   .write_enable_latch_o(write_enable_latch_o),
   .hardware_protected_mode_o(hardware_protected_mode_o),
   .quad_interface_enable_cmd_o(quad_interface_enable_cmd_o),
   .protected_region_o(protected_region_o)
);
`default_nettype wire

// File: test/spi_host_model.sv
// Purpose: Host side serial controller, mode 0
// Assumes: 12 ns serial clock, only inside frames
// Notes: Data line inverted when idle so stale bits never look valid
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
      rx = '0;
      #3 cs_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_o = tx[i];
         #6 sclk_o = 1'b1;
         rx = {rx[22:0], miso_i};
         #6 sclk_o = 1'b0;
      end
      #6 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #60;
   endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Purpose: Self-checking bench for the status register block
// Assumes: Short write cycle of 40 clocks, longer than one status poll
// Notes: Busy is polled over the link, as a host would
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import status_reg_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic wp_n = 1'b1;
   logic [23:0] rx;
   logic [15:0] v;
   int errors = 0;
   int check_count = 0;
   wire logic sclk, cs_n, mosi, so, so_oe, busy, write_enable_latch, hardware_protected_mode, quad;
   wire logic [15:0] region;
   wire miso = so_oe ? so : 1'bz;
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   spi_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
   status_reg_core #(.WRITE_CYCLES(40), .ARRAY_CYCLES(40),
      .BP_REGION_TABLE('{0: 16'h0000, default: 16'hA5A5})) dut_u (
      .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .serial_in_pin_i(mosi), .write_protect_n_i(wp_n), .hold_n_i(1'b1),
      .serial_out_o(so), .serial_out_oe_o(so_oe), .busy_flag_o(busy),
      .write_enable_latch_o(write_enable_latch), .hardware_protected_mode_o(hardware_protected_mode),
      .quad_interface_enable_cmd_o(quad), .protected_region_o(region));
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      host_u.xfer({16'h0000, op}, 8, rx);
   endtask
   task automatic rd_sr;
      host_u.xfer({OP_STATUS_READ, 16'h0000}, 24, rx);
      v = rx[15:0];
   endtask
   task automatic wr_sr(input logic [7:0] d);
      cmd(OP_WRITE_ENABLE);
      host_u.xfer({8'h00, OP_STATUS_WRITE, d}, 16, rx);
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 40; i++) begin
         rd_sr();
         if (v[0] === 1'b0) return;
      end
      check("idle", v, 16'h0000);
   endtask
   task automatic set_wp(input logic b);
      @(posedge clock_i) #1 wp_n = b;
      repeat (6) @(posedge clock_i);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      errors++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clock_i);
      #1 rst_i = 1'b0;
      repeat (4) @(posedge clock_i);
      rd_sr();
      check("reset status", v, 16'h0000);
      check("reset outs", {busy, write_enable_latch, hardware_protected_mode, quad}, 16'h0000);
      host_u.xfer({8'h00, OP_STATUS_WRITE, 8'hFC}, 16, rx);
      wait_idle();
      check("write no latch", v, 16'h0000);
      cmd(OP_WRITE_ENABLE);
      rd_sr();
      check("latch set", v, 16'h0202);
      cmd(OP_WRITE_DISABLE);
      rd_sr();
      check("latch clear", v, 16'h0000);
      $display("test basic done");
      wr_sr(8'h3F);
      rd_sr();
      check("read busy", v & 16'h0101, 16'h0101);
      wait_idle();
      check("stored", v, 16'h3C3C);
      check("region", region, 16'hA5A5);
      cmd(OP_WRITE_ENABLE);
      host_u.xfer({9'h000, OP_STATUS_WRITE, 7'h00}, 15, rx);
      rd_sr();
      check("short frame", v & 16'hFDFD, 16'h3C3C);
      cmd(OP_WRITE_DISABLE);
      $display("test write done");
      wr_sr(8'hBC);
      wait_idle();
      set_wp(1'b0);
      check("locked", hardware_protected_mode, 16'h0001);
      wr_sr(8'h00);
      wait_idle();
      check("locked write", v & 16'hFDFD, 16'hBCBC);
      cmd(OP_WRITE_DISABLE);
      set_wp(1'b1);
      wr_sr(8'h00);
      wait_idle();
      check("unlocked", v, 16'h0000);
      check("region zero", region, 16'h0000);
      $display("test protect done");
      cmd(OP_QUAD_IF_ENABLE);
      repeat (6) @(posedge clock_i);
      check("quad", quad, 16'h0001);
      $display("test quad done");
      conclude();
   end
endmodule
`default_nettype wire
